// *** include/lscr_pkg.sv ***
// Package for the LED sink current control register bank.
// Assumes an upstream two-wire serial decoder that presents byte writes and reads.
package lscr_pkg;
    // Register offsets on the serial register map.
    localparam logic [7:0] LSCR_OFS_DIM = 8'h0A;
    localparam logic [7:0] LSCR_OFS_LAW = 8'h0F;
    localparam logic [7:0] LSCR_OFS_SINK = 8'h10;
    // Values after reset: all zero.
    localparam logic [6:0] LSCR_RST_DIM = 7'h00;
    localparam logic [1:0] LSCR_RST_LAW = 2'h0;
    localparam logic [6:0] LSCR_RST_SINK = 7'h00;
    // Field positions.
    localparam int LSCR_DIM_MSB = 6;
    localparam int LSCR_LAW_MSB = 1;
    localparam int LSCR_SINK_MSB = 6;
    localparam int LSCR_NUM_SINKS = 7;
    // Off-time code meaning continuous on.
    localparam logic [1:0] LSCR_OFF_DISABLED = 2'h0;
    // Fade law encodings.
    typedef enum logic [1:0] {
        LSCR_LAW_LINEAR = 2'h0,
        LSCR_LAW_SQUARE = 2'h1,
        LSCR_LAW_CUBIC10 = 2'h2,
        LSCR_LAW_CUBIC11 = 2'h3
    } lscr_law_e;
endpackage

// *** verilog/lscr_regs.sv ***
// Register bank for dim current, sink fade law and per-sink enables.
// Assumes a serial-bus front end on mclk_i issuing single-cycle write and read strobes.
`timescale 1ns/1ns

module lscr_regs (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o,
    input wire logic dim_timeout_i,
    input wire logic dim_force_i,
    input wire logic [6:0] bright_code_i,
    input wire logic [13:0] sink_off_time_i,
    output logic [6:0] backlight_code_o,
    output logic square_law_o,
    output logic nonlinear_time_o,
    output logic [1:0] cubic_profile_o,
    output logic [6:0] sink_enable_o,
    output logic [6:0] sink_steady_on_o
);
    import lscr_pkg::*;

    typedef struct packed {
        logic [6:0] dim_current_code;
        logic [1:0] sink_law_select;
        logic [6:0] sink_on;
        logic [7:0] rdata;
        logic [6:0] bl_code;
        logic [6:0] steady;
    } lscr_state_s;

    lscr_state_s cur;
    lscr_state_s next_cur;

    // Per-sink steady check: enabled and off-time disabled.
    function automatic logic [6:0] steady_map(input logic [6:0] en, input logic [13:0] off);
        logic [6:0] r;
        r = '0;
        for (int i = 0; i < LSCR_NUM_SINKS; i++) begin
            r[i] = en[i] && (off[2*i +: 2] == LSCR_OFF_DISABLED);
        end
        return r;
    endfunction

    // Next-state logic; reserved bits are simply not stored, so they read zero.
    always_comb begin
        next_cur = cur;
        if (wr_en_i) begin
            case (addr_i)
                LSCR_OFS_DIM: next_cur.dim_current_code = wdata_i[LSCR_DIM_MSB:0];
                LSCR_OFS_LAW: next_cur.sink_law_select = wdata_i[LSCR_LAW_MSB:0];
                LSCR_OFS_SINK: next_cur.sink_on = wdata_i[LSCR_SINK_MSB:0];
                default: ;
            endcase
        end
        // Unmapped reads return zero rather than stale data.
        if (rd_en_i) begin
            case (addr_i)
                LSCR_OFS_DIM: next_cur.rdata = {1'b0, cur.dim_current_code};
                LSCR_OFS_LAW: next_cur.rdata = {6'h00, cur.sink_law_select};
                LSCR_OFS_SINK: next_cur.rdata = {1'b0, cur.sink_on};
                default: next_cur.rdata = 8'h00;
            endcase
        end
        // Dimmed code wins whenever a timeout or a forced dim is present.
        next_cur.bl_code = (dim_timeout_i || dim_force_i) ? cur.dim_current_code
                                                           : bright_code_i;
        next_cur.steady = steady_map(cur.sink_on, sink_off_time_i);
    end

    // State register.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur.dim_current_code <= LSCR_RST_DIM;
            cur.sink_law_select <= LSCR_RST_LAW;
            cur.sink_on <= LSCR_RST_SINK;
            cur.rdata <= 8'h00;
            cur.bl_code <= 7'h00;
            cur.steady <= 7'h00;
        end else begin
            cur <= next_cur;
        end
    end

    // Law decode: only 00 is linear mapping; the high bit alone picks nonlinear timing.
    assign square_law_o = (cur.sink_law_select != LSCR_LAW_LINEAR);
    assign nonlinear_time_o = cur.sink_law_select[1];
    assign cubic_profile_o = cur.sink_law_select;
    assign sink_enable_o = cur.sink_on;
    assign sink_steady_on_o = cur.steady;
    assign backlight_code_o = cur.bl_code;
    assign rdata_o = cur.rdata;

    // Checks on the register file and its decoded outputs, all on mclk_i.
    // Each write-side check looks one edge after the strobe, when the copy has landed.
    property p_dim_select;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (dim_timeout_i || dim_force_i) |=> backlight_code_o == $past(cur.dim_current_code);
    endproperty
    a_dim_select: assert property (p_dim_select) else $error("dim code not driven");

    property p_linear;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (wr_en_i && addr_i == LSCR_OFS_LAW && wdata_i[1:0] == 2'h0)
            |=> !square_law_o && !nonlinear_time_o;
    endproperty
    a_linear: assert property (p_linear) else $error("law 00 not linear");

    property p_square;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (wr_en_i && addr_i == LSCR_OFS_LAW && wdata_i[1:0] == 2'h1)
            |=> square_law_o && !nonlinear_time_o;
    endproperty
    a_square: assert property (p_square) else $error("law 01 wrong");

    property p_cubic;
        @(posedge mclk_i) disable iff (!reset_n_i)
        nonlinear_time_o |-> square_law_o;
    endproperty
    a_cubic: assert property (p_cubic) else $error("cubic without square map");

    property p_cubic_set;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (wr_en_i && addr_i == LSCR_OFS_LAW && wdata_i[1])
            |=> nonlinear_time_o && cubic_profile_o == $past(wdata_i[1:0]);
    endproperty
    a_cubic_set: assert property (p_cubic_set) else $error("cubic profile wrong");

    property p_sink_write;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (wr_en_i && addr_i == LSCR_OFS_SINK) |=> sink_enable_o == $past(wdata_i[6:0]);
    endproperty
    a_sink_write: assert property (p_sink_write) else $error("sink enables not stored");

    property p_steady;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (sink_enable_o[0] && sink_off_time_i[1:0] == 2'h0 && !wr_en_i)
            |=> sink_steady_on_o[0];
    endproperty
    a_steady: assert property (p_steady) else $error("sink1 not steady on");

    property p_reserved;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (rd_en_i && addr_i == LSCR_OFS_LAW) |=> rdata_o[7:2] == 6'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    // Outside a dim, the live code passes through one cycle later.
    property p_bright_pass;
        @(posedge mclk_i) disable iff (!reset_n_i)
        !(dim_timeout_i || dim_force_i) |=> backlight_code_o == $past(bright_code_i);
    endproperty
    a_bright_pass: assert property (p_bright_pass) else $error("bright code not driven");

    // A read of the dim register returns the stored code with bit 7 clear.
    property p_rd_dim;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (rd_en_i && addr_i == LSCR_OFS_DIM) |=> rdata_o == {1'b0, $past(cur.dim_current_code)};
    endproperty
    a_rd_dim: assert property (p_rd_dim) else $error("dim read wrong");

    // A read of the law register returns only the two law bits.
    property p_rd_law;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (rd_en_i && addr_i == LSCR_OFS_LAW) |=> rdata_o == {6'h00, $past(cur.sink_law_select)};
    endproperty
    a_rd_law: assert property (p_rd_law) else $error("law read wrong");

    // The enable register has no eighth sink, so its top bit always reads zero.
    property p_rd_sink;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (rd_en_i && addr_i == LSCR_OFS_SINK) |=> !rdata_o[7];
    endproperty
    a_rd_sink: assert property (p_rd_sink) else $error("sink read bit 7 set");

    // Offsets outside the map must not leak stale data onto the bus.
    property p_rd_unmapped;
        @(posedge mclk_i) disable iff (!reset_n_i)
        (rd_en_i && addr_i != LSCR_OFS_DIM && addr_i != LSCR_OFS_LAW
            && addr_i != LSCR_OFS_SINK) |=> rdata_o == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero");

    // Enables move only on a write to their own offset.
    property p_sink_hold;
        @(posedge mclk_i) disable iff (!reset_n_i)
        !(wr_en_i && addr_i == LSCR_OFS_SINK) |=> $stable(sink_enable_o);
    endproperty
    a_sink_hold: assert property (p_sink_hold) else $error("sink enables changed");

    // The fade law moves only on a write to its own offset.
    property p_law_hold;
        @(posedge mclk_i) disable iff (!reset_n_i)
        !(wr_en_i && addr_i == LSCR_OFS_LAW) |=> $stable(cubic_profile_o);
    endproperty
    a_law_hold: assert property (p_law_hold) else $error("fade law changed");

    // Sink 7 disabled on one edge is not reported as steady on at the next, whatever its off-time.
    property p_steady_off;
        @(posedge mclk_i) disable iff (!reset_n_i)
        !sink_enable_o[6] |=> !sink_steady_on_o[6];
    endproperty
    a_steady_off: assert property (p_steady_off) else $error("sink7 steady while off");

    // Scenario covers: square and cubic-11 laws, forced dim, all sinks on and a steady sink.

    c_dim: cover property (@(posedge mclk_i) disable iff (!reset_n_i) dim_force_i ##1 1'b1);
    c_cubic11: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
        cubic_profile_o == 2'h3);
    c_all_on: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
        sink_enable_o == 7'h7F);
    c_square: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
        cubic_profile_o == 2'h1);
    c_steady: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
        sink_steady_on_o != 7'h00);
endmodule // lscr_regs

// *** dv/lscr_host_model.sv ***
// Host model that issues single-byte register writes and reads.
// Assumes the register bank takes strobes on the rising edge of clk_i.
`timescale 1ns/1ns
module lscr_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic wr_en_o,
    output logic rd_en_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    // Start idle so no strobe is seen during reset.
    initial begin
        {wr_en_o, rd_en_o} = 2'b00;
        {addr_o, wdata_o} = 16'h0000;
    end
    // Write, held to the taking edge; released lines show the inverse so stale data cannot pass.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_en_o <= 1'b1;
        {addr_o, wdata_o} <= {a, d};
        @(posedge clk_i);
        wr_en_o <= 1'b0;
        {addr_o, wdata_o} <= ~{a, d};
    endtask
    // Read; the data is taken one edge after the strobe was seen.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        rd_en_o <= 1'b1;
        addr_o <= a;
        @(posedge clk_i);
        rd_en_o <= 1'b0;
        addr_o <= ~a;
        @(posedge clk_i);
        d = rdata_i;
    endtask
endmodule // lscr_host_model

// *** dv/lscr_regs_tb.sv ***
// Self-checking bench for the dim code, fade law and sink enable registers.
// Assumes lscr_pkg and the host model are compiled first.
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); miscompares++; end end
module lscr_regs_tb;
    import lscr_pkg::*;
    logic mclk_i, reset_n_i, dim_timeout_i, dim_force_i, wr_en, rd_en, square_law, nonlinear;
    logic [7:0] addr, wdata, rdata, rv;
    logic [6:0] bright_code_i, backlight_code, sink_enable, sink_steady;
    logic [13:0] sink_off_time_i;
    logic [1:0] profile;
    int miscompares = 0;
    int n_tests = 0;
    int k;
    lscr_regs dut_u (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .dim_timeout_i(dim_timeout_i),
        .dim_force_i(dim_force_i), .bright_code_i(bright_code_i),
        .sink_off_time_i(sink_off_time_i), .backlight_code_o(backlight_code),
        .square_law_o(square_law), .nonlinear_time_o(nonlinear), .cubic_profile_o(profile),
        .sink_enable_o(sink_enable), .sink_steady_on_o(sink_steady));
    lscr_host_model host_u (.clk_i(mclk_i), .rdata_i(rdata), .wr_en_o(wr_en), .rd_en_o(rd_en),
        .addr_o(addr), .wdata_o(wdata));
    // Free-running clock.
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Reads a register and compares it.
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, rv);
        `CHK("rdata", e, rv)
    endtask
    // Two edges, since some outputs are registered behind the register.
    task automatic settle();
        repeat (2) @(posedge mclk_i);
    endtask
    // Watchdog; the tests need well under a hundred cycles.
    initial begin
        repeat (2000) @(posedge mclk_i);
        miscompares++;
        report_and_stop();
    end
    // Main sequence.
    initial begin
        reset_n_i = 1'b0;
        {dim_timeout_i, dim_force_i} = 2'b00;
        bright_code_i = 7'h15;
        sink_off_time_i = 14'h0030;
        repeat (5) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rchk(LSCR_OFS_DIM, 8'h00);
        rchk(LSCR_OFS_LAW, 8'h00);
        rchk(LSCR_OFS_SINK, 8'h00);
        host_u.wr(LSCR_OFS_DIM, 8'hFF);
        rchk(LSCR_OFS_DIM, 8'h7F);
        `CHK("bright", 7'h15, backlight_code)
        dim_timeout_i <= 1'b1;
        settle();
        `CHK("dim_timeout", 7'h7F, backlight_code)
        dim_timeout_i <= 1'b0;
        dim_force_i <= 1'b1;
        settle();
        `CHK("dim_force", 7'h7F, backlight_code)
        for (k = 0; k < 4; k++) begin
            host_u.wr(LSCR_OFS_LAW, {6'h3F, k[1:0]});
            rchk(LSCR_OFS_LAW, {6'h00, k[1:0]});
            `CHK("square", k != 0, square_law)
            `CHK("nonlinear", k[1], nonlinear)
            `CHK("profile", k[1:0], profile)
        end
        host_u.wr(LSCR_OFS_SINK, 8'hFF);
        rchk(LSCR_OFS_SINK, 8'h7F);
        host_u.wr(LSCR_OFS_SINK, 8'h05);
        settle();
        `CHK("sink_enable", 7'h05, sink_enable)
        `CHK("steady_on", 7'h01, sink_steady)
        host_u.wr(8'h0B, 8'hAA);
        rchk(8'h0B, 8'h00);
        report_and_stop();
    end
endmodule // lscr_regs_tb
